// file: onoff_pkg.sv
package onoff_pkg;

  // ----------------------------------------------------------------
  // Timing base
  // ----------------------------------------------------------------
  localparam int TICK_HZ          = 32768;           // Slow timing domain rate
  localparam int DEBOUNCE_MS      = 30;              // Key debounce time
  localparam int DEBOUNCE_TICKS   = (DEBOUNCE_MS * TICK_HZ + 999) / 1000;
  localparam int SECOND_MS        = 1000;            // Key one-second mark
  localparam int SECOND_TICKS     = (SECOND_MS * TICK_HZ + 999) / 1000;
  localparam int REG_RESET_MS     = 30;              // Shutdown to register reset
  localparam int REG_RESET_TICKS  = (REG_RESET_MS * TICK_HZ + 999) / 1000;
  localparam int RESTART_MS       = 100;             // Register reset to wakeup
  localparam int RESTART_TICKS    = (RESTART_MS * TICK_HZ + 999) / 1000;
  localparam int EXTRA_STEP_MS    = 1000;            // Step of the extra key delay
  localparam int EXTRA_STEP_TICKS = (EXTRA_STEP_MS * TICK_HZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENT  = 8'h08;
  localparam logic [7:0] ADDR_SEQ    = 8'h0C;

  localparam int CTRL_MR_EN    = 0;                  // Manual reset enable
  localparam int CTRL_MRT_LSB  = 1;                  // Manual reset time, 3 bits
  localparam int CTRL_DLY_LSB  = 4;                  // Extra key delay, 2 bits
  localparam int CTRL_MASK_LSB = 6;                  // Wake masks, 5 bits
  localparam logic [10:0] CTRL_RESET = 11'h7CB;      // Enabled, 8 s, no delay, all wake

  localparam int EV_KEY_ASSERT   = 0;
  localparam int EV_KEY_DEASSERT = 1;
  localparam int EV_KEY_SECOND   = 2;
  localparam int EV_MR_WARN      = 3;
  localparam int EV_MR_DONE      = 4;
  localparam int EV_WAKE         = 5;
  localparam int EV_SRC_LSB      = 6;                // Nine wake source records
  localparam int EV_HARD_RESET   = 15;

  localparam int SEQ_OFF_BIT = 0;                    // Write 1 turns sequencers off

  // ----------------------------------------------------------------
  // Manual reset sequence
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MR_IDLE    = 3'b000,
    MR_HOLD    = 3'b001,
    MR_SHUT    = 3'b010,
    MR_RESTART = 3'b011,
    MR_DONE    = 3'b100
  } mr_state_type;

  // Seconds of press selected by the manual reset time code
  function automatic logic [3:0] mr_seconds(input logic [2:0] code);
    case (code)
      3'h0: mr_seconds = 4'h2;
      3'h1: mr_seconds = 4'h3;
      3'h2: mr_seconds = 4'h4;
      3'h3: mr_seconds = 4'h5;
      3'h4: mr_seconds = 4'h6;
      3'h5: mr_seconds = 4'h8;
      3'h6: mr_seconds = 4'hA;
      default: mr_seconds = 4'hC;
    endcase
  endfunction

endpackage

// file: key_event_if.sv
interface key_event_if;
  logic level;   // Debounced asserted state
  logic rise;    // Pulse on debounced assertion
  logic fall;    // Pulse on debounced deassertion

  modport source (output level, output rise, output fall);
  modport sink   (input level, input rise, input fall);
endinterface

// file: input_sync.sv
module input_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] din_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // ----------------------------------------------------------------
  // Two-stage synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1  <= '0;
      stage2  <= '0;
      level_o <= '0;
      rise_o  <= '0;
    end else begin
      stage1  <= din_i;
      stage2  <= stage1;
      level_o <= stage2;
      rise_o  <= stage2 & ~level_o;
    end
  end

endmodule

// file: key_debounce.sv
module key_debounce
  import onoff_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  input  wire logic        key_i,
  input  wire logic [17:0] extra_i,
  key_event_if.source      ev
);

  logic [17:0] count;
  logic [17:0] limit;

  // Assertion waits for debounce plus extra delay, release for debounce only
  assign limit = ev.level ? 18'(DEBOUNCE_TICKS - 1) : 18'(DEBOUNCE_TICKS - 1) + extra_i;

  // ----------------------------------------------------------------
  // Stable-time counter on slow ticks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count    <= '0;
      ev.level <= 1'b0;
      ev.rise  <= 1'b0;
      ev.fall  <= 1'b0;
    end else begin
      ev.rise <= 1'b0;
      ev.fall <= 1'b0;
      if (key_i == ev.level) begin
        count <= '0;
      end else if (tick_i) begin
        if (count >= limit) begin
          count    <= '0;
          ev.level <= key_i;
          ev.rise  <= key_i;
          ev.fall  <= ~key_i;
        end else begin
          count <= count + 18'h00001;
        end
      end
    end
  end

endmodule

// file: onoff_wakeup_manual_reset.sv
// Implementation choices: register access over Wishbone and the placing of the registers.
module onoff_wakeup_manual_reset
  import onoff_pkg::*;
#(
  parameter int SECOND_CNT = SECOND_TICKS,
  parameter int EXTRA_STEP = EXTRA_STEP_TICKS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rtc_32k_i,
  input  wire logic        power_key_input_i,
  input  wire logic        sleep_ctrl_input_i,
  input  wire logic        core_rail_enable_input_i,
  input  wire logic        adapter_present_input_i,
  input  wire logic        bidir_reset_pin_i,
  input  wire logic        battery_door_input_i,
  input  wire logic        momentary_loss_event_i,
  input  wire logic        alarm_one_event_i,
  input  wire logic        alarm_two_event_i,
  input  wire logic        main_battery_low_i,
  input  wire logic        key_polarity_fuse_i,
  input  wire logic        auto_restart_fuse_i,
  output logic             sequencer_zero_enable_o,
  output logic             sequencer_one_enable_o,
  output logic             manual_reset_out_o,
  output logic             global_shutdown_o,
  output logic             key_assert_irq_o,
  output logic             key_deassert_irq_o,
  output logic             key_second_irq_o,
  output logic             manual_reset_warning_irq_o,
  output logic             hard_reset_flag_o,
  output logic             wake_event_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [10:0]  sync_in;
  logic [10:0]  sync_lvl;
  logic [10:0]  sync_rise;
  logic         tick;
  logic         key_norm;
  logic [10:0]  ctrl;
  logic         manual_reset_enable;
  logic [2:0]   manual_reset_time_sel;
  logic [1:0]   key_extra_delay_sel;
  logic [4:0]   wake_mask;
  logic [17:0]  extra_ticks;
  logic [8:0]   wake_src;
  logic [8:0]   wake_allow;
  logic [8:0]   wake_hit;
  logic         wake_any;
  logic         restart_wake;
  logic         reg_reset;
  logic [15:0]  event_bits;
  logic [15:0]  event_set;
  logic [15:0]  event_clr;
  logic         bus_req;
  logic         bus_wr;
  logic [3:0]   mr_sec;
  logic [3:0]   warn_sec;
  logic [3:0]   next_sec;
  logic [15:0]  sub_cnt;
  logic [3:0]   sec_cnt;
  logic [11:0]  phase_cnt;
  logic         sec_wrap;
  logic         second_hit;
  logic         warn_hit;
  logic         mr_hit;
  mr_state_type state;
  key_event_if  key_ev ();

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  assign sync_in = {main_battery_low_i, alarm_two_event_i, alarm_one_event_i,
                    momentary_loss_event_i, battery_door_input_i, bidir_reset_pin_i,
                    adapter_present_input_i, core_rail_enable_input_i,
                    sleep_ctrl_input_i, power_key_input_i, rtc_32k_i};

  // The eleven pin inputs, the slow clock among them, pass two flip-flops first; the fuses and the bus are not synchronised
  input_sync #(
    .WIDTH (11)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .din_i   (sync_in),
    .level_o (sync_lvl),
    .rise_o  (sync_rise)
  );

  assign tick     = sync_rise[0];
  assign key_norm = sync_lvl[1] ^ key_polarity_fuse_i;

  // ----------------------------------------------------------------
  // Key debounce
  // ----------------------------------------------------------------
  assign extra_ticks = 18'(key_extra_delay_sel) * 18'(EXTRA_STEP);

  // Debounced key with extra assertion delay on slow ticks
  key_debounce u_debounce (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (tick),
    .key_i   (key_norm),
    .extra_i (extra_ticks),
    .ev      (key_ev.source)
  );

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign manual_reset_enable   = ctrl[CTRL_MR_EN];
  assign manual_reset_time_sel = ctrl[CTRL_MRT_LSB +: 3];
  assign key_extra_delay_sel   = ctrl[CTRL_DLY_LSB +: 2];
  assign wake_mask             = ctrl[CTRL_MASK_LSB +: 5];

  // ----------------------------------------------------------------
  // Press timing
  // ----------------------------------------------------------------
  assign mr_sec   = mr_seconds(manual_reset_time_sel);
  assign warn_sec = (manual_reset_time_sel == 3'h0) ? 4'h1 :
                    mr_seconds(manual_reset_time_sel - 3'h1);
  assign sec_wrap   = tick && (sub_cnt == 16'(SECOND_CNT - 1));
  assign next_sec   = sec_cnt + 4'h1;
  assign second_hit = (state == MR_HOLD) && sec_wrap && (next_sec == 4'h1);
  assign warn_hit   = (state == MR_HOLD) && sec_wrap && (next_sec == warn_sec);
  assign mr_hit     = (state == MR_HOLD) && sec_wrap && (next_sec == mr_sec);

  // Second counters run only while held, cleared otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_cnt <= '0;
      sec_cnt <= '0;
    end else if (state != MR_HOLD || key_ev.fall) begin
      sub_cnt <= '0;
      sec_cnt <= '0;
    end else if (sec_wrap) begin
      sub_cnt <= '0;
      sec_cnt <= next_sec;
    end else if (tick) begin
      sub_cnt <= sub_cnt + 16'h0001;
    end
  end

  // Phase counter for shutdown and restart waits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_cnt <= '0;
    end else if ((state != MR_SHUT && state != MR_RESTART) || reg_reset) begin
      phase_cnt <= '0;
    end else if (tick) begin
      phase_cnt <= phase_cnt + 12'h001;
    end
  end

  assign reg_reset    = (state == MR_SHUT) && tick &&
                        (phase_cnt == 12'(REG_RESET_TICKS - 1));
  assign restart_wake = (state == MR_RESTART) && tick &&
                        (phase_cnt == 12'(RESTART_TICKS - 1)) && auto_restart_fuse_i;

  // ----------------------------------------------------------------
  // Manual reset sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= MR_IDLE;
    end else begin
      case (state)
        MR_IDLE: begin
          if (key_ev.rise) begin
            state <= MR_HOLD;
          end
        end
        MR_HOLD: begin
          if (key_ev.fall) begin
            state <= MR_IDLE;
          end else if (mr_hit) begin
            state <= manual_reset_enable ? MR_SHUT : MR_DONE;
          end
        end
        MR_SHUT: begin
          if (reg_reset) begin
            state <= MR_RESTART;
          end
        end
        MR_RESTART: begin
          if (tick && phase_cnt == 12'(RESTART_TICKS - 1)) begin
            state <= MR_DONE;
          end
        end
        MR_DONE: begin
          if (!key_ev.level) begin
            state <= MR_IDLE;
          end
        end
        default: begin
          state <= MR_IDLE;
        end
      endcase
    end
  end

  // Manual reset output and global shutdown follow the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      manual_reset_out_o <= 1'b0;
      global_shutdown_o  <= 1'b0;
    end else begin
      manual_reset_out_o <= (state == MR_SHUT);
      global_shutdown_o  <= (state == MR_SHUT) || (state == MR_RESTART);
    end
  end

  // Interrupt pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_assert_irq_o           <= 1'b0;
      key_deassert_irq_o         <= 1'b0;
      key_second_irq_o           <= 1'b0;
      manual_reset_warning_irq_o <= 1'b0;
    end else begin
      key_assert_irq_o           <= key_ev.rise;
      key_deassert_irq_o         <= key_ev.fall;
      key_second_irq_o           <= second_hit;
      manual_reset_warning_irq_o <= warn_hit && manual_reset_enable;
    end
  end

  // ----------------------------------------------------------------
  // Wakeup qualification
  // ----------------------------------------------------------------
  assign wake_src   = {sync_rise[9:2], key_ev.rise};
  assign wake_allow = {wake_mask[3], wake_mask[2], 1'b1, wake_mask[1], 1'b1,
                       wake_mask[0], 1'b1, 1'b1, wake_mask[4]};
  assign wake_hit   = wake_src & wake_allow &
                      {9{~sync_lvl[10] & ~global_shutdown_o & (state != MR_SHUT)}};
  assign wake_any   = (|wake_hit) || restart_wake;

  // Sequencer enables: set by wakes, dropped by shutdown or software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sequencer_zero_enable_o <= 1'b0;
      sequencer_one_enable_o  <= 1'b0;
      wake_event_o            <= 1'b0;
    end else begin
      wake_event_o <= wake_any;
      if (mr_hit && manual_reset_enable) begin
        sequencer_zero_enable_o <= 1'b0;
        sequencer_one_enable_o  <= 1'b0;
      end else if (wake_any) begin
        sequencer_zero_enable_o <= 1'b1;
        sequencer_one_enable_o  <= 1'b1;
      end else if (bus_wr && wb_adr_i == ADDR_SEQ && wb_sel_i[0] &&
                   wb_dat_i[SEQ_OFF_BIT]) begin
        sequencer_zero_enable_o <= 1'b0;
        sequencer_one_enable_o  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event record
  // ----------------------------------------------------------------
  always_comb begin
    event_set                  = '0;
    event_set[EV_KEY_ASSERT]   = key_ev.rise;
    event_set[EV_KEY_DEASSERT] = key_ev.fall;
    event_set[EV_KEY_SECOND]   = second_hit;
    event_set[EV_MR_WARN]      = warn_hit && manual_reset_enable;
    event_set[EV_MR_DONE]      = reg_reset;
    event_set[EV_WAKE]         = wake_any;
    event_set[EV_SRC_LSB +: 9] = wake_hit;
    event_set[EV_HARD_RESET]   = restart_wake;
  end

  // Write-one-to-clear mask from the bus
  always_comb begin
    event_clr = '0;
    if (bus_wr && wb_adr_i == ADDR_EVENT) begin
      event_clr[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
      event_clr[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00;
    end
  end

  // Sticky events; a set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_bits <= '0;
    end else if (reg_reset) begin
      event_bits <= {event_bits[EV_HARD_RESET], 15'h0000} | event_set;
    end else begin
      event_bits <= (event_bits & ~event_clr) | event_set;
    end
  end

  assign hard_reset_flag_o = event_bits[EV_HARD_RESET];

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || reg_reset) begin
      ctrl <= CTRL_RESET;
    end else if (bus_wr && wb_adr_i == ADDR_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl[10:8] <= wb_dat_i[10:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i;

  // One-cycle answer; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i) begin
        if (wb_adr_i == ADDR_CTRL) begin
          wb_dat_o <= {21'h000000, ctrl};
        end else if (wb_adr_i == ADDR_STATUS) begin
          wb_dat_o <= {24'h000000, state, global_shutdown_o, manual_reset_out_o,
                       sequencer_one_enable_o, sequencer_zero_enable_o, key_ev.level};
        end else if (wb_adr_i == ADDR_EVENT) begin
          wb_dat_o <= {16'h0000, event_bits};
        end else begin
          wb_dat_o <= '0;
        end
      end
    end
  end

endmodule

// file: onoff_asserts.sv
module onoff_asserts (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        auto_restart_fuse_i,
  input  wire logic        sequencer_zero_enable_o,
  input  wire logic        sequencer_one_enable_o,
  input  wire logic        manual_reset_out_o,
  input  wire logic        global_shutdown_o,
  input  wire logic        key_assert_irq_o,
  input  wire logic        hard_reset_flag_o,
  input  wire logic        wake_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Steps
  // ----------------------------------------------------------------
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence mr_on_s;
    $rose(manual_reset_out_o);
  endsequence
  ack_one_a:
    assert property (req_s |=> wb_ack_o) else $error("ack not one cycle after request");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data without ack");
  irq_pulse_a:
    assert property (key_assert_irq_o |=> !key_assert_irq_o) else $error("key irq held");
  mr_shut_a:
    assert property (manual_reset_out_o |-> global_shutdown_o && !sequencer_zero_enable_o)
      else $error("reset out without shutdown");
  mr_hold_a:
    assert property (mr_on_s |=> manual_reset_out_o [*8]) else $error("reset out too short");
  seq_pair_a:
    assert property (sequencer_zero_enable_o == sequencer_one_enable_o)
      else $error("sequencers differ");
  wake_seq_a:
    assert property (wake_event_o |-> ##[0:2] sequencer_zero_enable_o)
      else $error("wake without sequencer");
  hard_fuse_a:
    assert property ($rose(hard_reset_flag_o) |-> auto_restart_fuse_i)
      else $error("hard flag without fuse");
  wake_block_a:
    assert property (wake_event_o |-> !manual_reset_out_o) else $error("wake in shutdown");
endmodule

bind onoff_wakeup_manual_reset onoff_asserts onoff_asserts_i (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .auto_restart_fuse_i,
  .sequencer_zero_enable_o, .sequencer_one_enable_o, .manual_reset_out_o,
  .global_shutdown_o, .key_assert_irq_o, .hard_reset_flag_o, .wake_event_o);

// file: key_pad_model.sv
module key_pad_model (
  input  wire logic clk_i,
  input  wire logic press_i,
  input  wire logic active_low_i,
  output logic      rtc_o,
  output logic      key_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div = 2'h0;
  initial rtc_o = 1'b0;
  // Free running slow clock, eight fast cycles a period
  always @(posedge clk_i) begin
    div <= div + 2'h1;
    if (div == 2'h3) rtc_o <= ~rtc_o;
  end
  // Key pad level follows the strap polarity
  assign key_o = press_i ^ active_low_i;
endmodule

// file: tb_onoff_wakeup_manual_reset.sv
module tb_onoff_wakeup_manual_reset;
  timeunit 1ns;
  timeprecision 1ps;
  import onoff_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, rtc_32k_i, power_key_input_i, press = 1'b0;
  logic [7:0]  wk = 8'h00;
  logic        main_battery_low_i = 1'b0, key_polarity_fuse_i = 1'b1;
  logic        auto_restart_fuse_i = 1'b1, sequencer_zero_enable_o, sequencer_one_enable_o;
  logic        manual_reset_out_o, global_shutdown_o, key_assert_irq_o, key_deassert_irq_o;
  logic        key_second_irq_o, manual_reset_warning_irq_o, hard_reset_flag_o, wake_event_o;
  int          error_cnt = 0, total_checks = 0, cyc = 0, ticks = 0, t0;
  int          quiet_src[5] = '{2, 4, 6, 7, 0};
  // ----------------------------------------------------------------
  // Block and key pad
  // ----------------------------------------------------------------
  onoff_wakeup_manual_reset #(.SECOND_CNT(64), .EXTRA_STEP(16)) onoff_wakeup_manual_reset_i (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .rtc_32k_i, .power_key_input_i, .sleep_ctrl_input_i(wk[0]),
    .core_rail_enable_input_i(wk[1]), .adapter_present_input_i(wk[2]),
    .bidir_reset_pin_i(wk[3]), .battery_door_input_i(wk[4]), .momentary_loss_event_i(wk[5]),
    .alarm_one_event_i(wk[6]), .alarm_two_event_i(wk[7]), .main_battery_low_i,
    .key_polarity_fuse_i, .auto_restart_fuse_i, .sequencer_zero_enable_o,
    .sequencer_one_enable_o, .manual_reset_out_o, .global_shutdown_o, .key_assert_irq_o,
    .key_deassert_irq_o, .key_second_irq_o, .manual_reset_warning_irq_o, .hard_reset_flag_o,
    .wake_event_o);
  key_pad_model key_pad_model_i (.clk_i, .press_i(press), .active_low_i(key_polarity_fuse_i),
    .rtc_o(rtc_32k_i), .key_o(power_key_input_i));
  initial forever #2.5 clk_i = ~clk_i;
  // Cycle ceiling and slow tick count
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  always @(posedge rtc_32k_i) ticks <= ticks + 1;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rng(input string n, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("MISMATCH %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask
  // One classic cycle, held until ack
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return key_assert_irq_o;
      1: return key_second_irq_o;
      2: return manual_reset_warning_irq_o;
      3: return manual_reset_out_o;
      4: return wake_event_o;
      5: return !manual_reset_out_o;
      default: return key_deassert_irq_o;
    endcase
  endfunction
  // Waits for the selected output; the cycle ceiling ends a hang
  task automatic wait_out(input int s);
    while (pick(s) !== 1'b1) begin
      @(posedge clk_i);
    end
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic        seen;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b0, ADDR_CTRL, 32'h0, q);
    chk("ctrl reset", 32'h7CB, q);
    bus(1'b0, 8'h10, 32'h0, q);
    chk("unmapped", 32'h0, q);
    for (int i = 0; i < 8; i++) begin
      wk[i] <= 1'b1;
      wait_out(4);
      wk[i] <= 1'b0;
      bus(1'b0, ADDR_EVENT, 32'h0, q);
      chk("source", 32'h1 << (7 + i), q & (32'h1 << (7 + i)));
      bus(1'b1, ADDR_EVENT, 32'hFFFF, q);
    end
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk("seq on", 32'h6, q & 32'h6);
    bus(1'b1, ADDR_CTRL, 32'h003, q);
    for (int j = 0; j < 5; j++) begin
      main_battery_low_i <= (j == 4);
      repeat (8) @(posedge clk_i);
      wk[quiet_src[j]] <= 1'b1;
      seen = 1'b0;
      repeat (30) begin
        @(posedge clk_i);
        seen = seen | wake_event_o;
      end
      wk[quiet_src[j]] <= 1'b0;
      chk("blocked wake", 32'h0, {31'h0, seen});
    end
    main_battery_low_i <= 1'b0;
    bus(1'b1, ADDR_SEQ, 32'h1, q);
    press <= 1'b1;
    t0 = ticks;
    wait_out(0);
    rng("debounce", 982, 987, ticks - t0);
    chk("key masked", 32'h0, {31'h0, wake_event_o});
    t0 = ticks;
    wait_out(1);
    rng("second", 63, 65, ticks - t0);
    wait_out(2);
    rng("warning", 127, 129, ticks - t0);
    wait_out(3);
    rng("manual reset", 191, 193, ticks - t0);
    t0 = ticks;
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk("seq shut", 32'h0, q & 32'h6);
    chk("shutdown", 32'h1, {31'h0, global_shutdown_o});
    wait_out(5);
    rng("reg reset", 982, 986, ticks - t0);
    t0 = ticks;
    bus(1'b0, ADDR_CTRL, 32'h0, q);
    chk("ctrl restored", 32'h7CB, q);
    wait_out(4);
    rng("restart", 3274, 3279, ticks - t0);
    chk("hard flag", 32'h1, {31'h0, hard_reset_flag_o});
    seen = 1'b0;
    repeat (4400) begin
      @(posedge clk_i);
      seen = seen | manual_reset_out_o;
    end
    chk("one shutdown", 32'h0, {31'h0, seen});
    press <= 1'b0;
    t0 = ticks;
    wait_out(6);
    rng("release", 982, 987, ticks - t0);
    bus(1'b1, ADDR_CTRL, 32'h7DB, q);
    press <= 1'b1;
    t0 = ticks;
    wait_out(0);
    rng("delayed press", 998, 1003, ticks - t0);
    chk("key wake", 32'h1, {31'h0, wake_event_o});
    tally_and_finish();
  end
endmodule
